// ===== common/fdcr_defines.svh
// Offsets, field positions, reset values and timing counts for the block
// ==========================================================================
// Function
// - Read/write data port at offset 5
// - FIFO disabled after reset; configure enables
// - Command start bypasses the FIFO
// - Execution phase entry flushes the FIFO
// - Missed service terminates command and transfer
// - Write underrun finishes sector with zeros
// - Read-only input status at offset 7
// - Basic mode drives only status bit 7
// - Bit 7 inverted change, forced by config
// - Enhanced bit 0 low-density flag, reset 1
// - Enhanced bits 1-2 rate, 3-6 ones
// - Extended layout: rate, noprec, dma, zeros
// - Rate keeps soft reset, hard reset 10
// - Write-only rate config at offset 7
// - Extended bit 2 stores noprec flag
// - Latest write of either register wins
// - Request flag set only when transfer allowed
// - Direction flag: 1 read, 0 write
`ifndef FDCR_DEFINES_SVH
`define FDCR_DEFINES_SVH

// ==========================================================================
// Register indexes (byte address is four times the index)
`define FDCR_IDX_DATA 4'h5
`define FDCR_IDX_STAT 4'h7
`define FDCR_IDX_CTRL 4'h8
`define FDCR_IDX_INFO 4'h9

// ==========================================================================
// Control register fields
`define FDCR_CTRL_FIFO_EN 0
`define FDCR_CTRL_THR_LO 4
`define FDCR_CTRL_THR_HI 7
`define FDCR_CTRL_FORCE_LO 8
`define FDCR_CTRL_FORCE_HI 9

// ==========================================================================
// Rate configuration fields and reset values
`define FDCR_CFG_NOPREC 2
`define FDCR_RATE_RESET 2'h2
`define FDCR_RATE_500K 2'h0
`define FDCR_RATE_1M 2'h3
`define FDCR_FIFO_DEPTH 5'h10
`define FDCR_ZERO_BYTE 8'h00

// ==========================================================================
// Host service margin in nanoseconds and in cycles of the clock period
`define FDCR_CLK_NS 4
`define FDCR_LAT_MARGIN_NS 1500
`define FDCR_LAT_MARGIN_CYC (`FDCR_LAT_MARGIN_NS / `FDCR_CLK_NS)

`endif

// ===== common/fdcr_pkg.sv
// Types shared by the data port and rate register block
package fdcr_pkg;

  // Interface layout selected by the static mode input
  typedef enum logic [1:0]
  {
    FDCR_MODE_BASIC = 2'h0,
    FDCR_MODE_ENH = 2'h1,
    FDCR_MODE_EXT = 2'h2
  } fdcr_mode_e;

  // Command phase as reported by the controller core
  typedef enum logic [1:0]
  {
    FDCR_PH_IDLE = 2'h0,
    FDCR_PH_CMD = 2'h1,
    FDCR_PH_EXEC = 2'h3,
    FDCR_PH_RES = 2'h2
  } fdcr_phase_e;

endpackage

// ===== hdl/fdcr_regs.sv
// Data port FIFO, input status and rate configuration registers over APB
`timescale 1ns/1ns
`include "fdcr_defines.svh"

module fdcr_regs
(
  // Clock, reset and clock enable
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [7:0] data_lane_oe_out,
  // Static configuration and side inputs
  input wire logic [1:0] mode_sel_in,
  input wire logic soft_reset_in,
  input wire logic media_changed_n_in,
  input wire logic dor_dma_gate_in,
  input wire logic dsr_rate_wr_in,
  input wire logic [1:0] dsr_rate_in,
  // Controller core phase events
  input wire logic core_cmd_start_in,
  input wire logic core_exec_start_in,
  input wire logic core_result_start_in,
  input wire logic core_cmd_done_in,
  input wire logic core_dir_read_in,
  // Controller core byte exchange
  input wire logic core_push_in,
  input wire logic [7:0] core_push_data_in,
  input wire logic core_pull_in,
  output logic core_pull_valid_out,
  output logic [7:0] core_pull_data_out,
  // Status toward core and host
  output logic request_for_master_out,
  output logic transfer_direction_out,
  output logic core_abort_out,
  output logic core_underrun_out,
  output logic core_drain_done_out,
  output logic [1:0] rate_sel_out,
  output logic noprec_out
);

  // ========================================================================
  // Declarations
  logic [7:0] fifo_mem [0:15];
  logic [3:0] wr_ptr_ff, rd_ptr_ff, thr_ff, idx;
  logic [4:0] count_ff, cap, thr_lvl, free_cnt;
  logic [1:0] force_ff, rate_ff;
  logic [31:0] prdata_ff, nxt_prdata;
  logic [7:0] lane_oe_ff, pull_data_ff, stat_byte;
  logic fifo_en_ff, noprec_ff, ovr_ff, unr_ff, abort_ff, pop_armed_ff;
  logic pready_ff, pslverr_ff, pull_valid_ff, rqm_ff, dir_ff, drain_ff;
  fdcr_pkg::fdcr_phase_e phase_ff;
  fdcr_pkg::fdcr_mode_e mode;
  logic addr_ok, access, done, wr_done, rd_done, in_exec, flush, full;
  logic empty, host_push, core_push, push, host_pop, core_pop, pop;
  logic overrun_ev, underrun_ev, nxt_rqm;

  // Decode of a register index into mapped or not
  function automatic logic idx_mapped(input logic [3:0] i);
    idx_mapped = (i == `FDCR_IDX_DATA) || (i == `FDCR_IDX_STAT) ||
                 (i == `FDCR_IDX_CTRL) || (i == `FDCR_IDX_INFO);
  endfunction

  // ========================================================================
  // Bus decode
  // Static layout selection, unknown codes fall back to basic
  always_comb
  begin
    unique case (mode_sel_in)
      2'h1: mode = fdcr_pkg::FDCR_MODE_ENH;
      2'h2: mode = fdcr_pkg::FDCR_MODE_EXT;
      default: mode = fdcr_pkg::FDCR_MODE_BASIC;
    endcase
  end

  // Access phase and completion of a transfer
  assign idx = paddr_in[5:2];
  assign addr_ok = idx_mapped(idx) && (paddr_in[1:0] == 2'h0) &&
                   (paddr_in[7:6] == 2'h0);
  assign access = psel_in && penable_in;
  assign done = access && pready_ff && ce_in;
  assign wr_done = done && pwrite_in && addr_ok;
  assign rd_done = done && !pwrite_in && addr_ok;

  // ========================================================================
  // FIFO control
  assign in_exec = (phase_ff == fdcr_pkg::FDCR_PH_EXEC);
  // Outside execution or with FIFO off only one byte is held
  assign cap = (fifo_en_ff && in_exec) ? `FDCR_FIFO_DEPTH : 5'h01;
  assign full = (count_ff >= cap);
  assign empty = (count_ff == 5'h00);
  assign flush = core_exec_start_in || core_cmd_start_in ||
                 soft_reset_in;

  // Push and pop sources chosen by transfer direction
  assign host_push = wr_done && (idx == `FDCR_IDX_DATA) && !dir_ff &&
                     !full;
  assign core_push = core_push_in && dir_ff && !full;
  assign push = host_push || core_push;
  assign host_pop = rd_done && (idx == `FDCR_IDX_DATA) && pop_armed_ff &&
                    dir_ff;
  assign core_pop = core_pull_in && !dir_ff && !empty;
  assign pop = host_pop || core_pop;

  // Service failures seen while a transfer runs
  assign overrun_ev = in_exec && core_push_in && dir_ff && full;
  assign underrun_ev = in_exec && core_pull_in && !dir_ff && empty;

  // Byte storage
  always_ff @(posedge clk_sys_in)
  begin
    if (ce_in && push)
    begin
      fifo_mem[wr_ptr_ff] <= host_push ? pwdata_in[7:0] : core_push_data_in;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in || (ce_in && flush))
    begin
      wr_ptr_ff <= 4'h0;
      rd_ptr_ff <= 4'h0;
      count_ff <= 5'h00;
    end
    else if (ce_in)
    begin
      wr_ptr_ff <= wr_ptr_ff + {3'h0, push};
      rd_ptr_ff <= rd_ptr_ff + {3'h0, pop};
      count_ff <= count_ff + {4'h0, push} - {4'h0, pop};
    end
  end

  // ========================================================================
  // Command phase tracking
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      phase_ff <= fdcr_pkg::FDCR_PH_IDLE;
    end
    else if (ce_in)
    begin
      if (soft_reset_in || core_cmd_done_in)
      begin
        phase_ff <= fdcr_pkg::FDCR_PH_IDLE;
      end
      else if (core_cmd_start_in)
      begin
        phase_ff <= fdcr_pkg::FDCR_PH_CMD;
      end
      else if (core_exec_start_in)
      begin
        phase_ff <= fdcr_pkg::FDCR_PH_EXEC;
      end
      else if (core_result_start_in)
      begin
        phase_ff <= fdcr_pkg::FDCR_PH_RES;
      end
    end
  end

  // Sticky failure flags, a new failure beats the clear at command start
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      ovr_ff <= 1'b0;
      unr_ff <= 1'b0;
      abort_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      ovr_ff <= overrun_ev || (ovr_ff && !core_cmd_start_in &&
                               !soft_reset_in);
      unr_ff <= underrun_ev || (unr_ff && !core_cmd_start_in &&
                                !soft_reset_in);
      abort_ff <= overrun_ev || underrun_ev || ((ovr_ff || unr_ff) &&
                  !core_cmd_start_in && !soft_reset_in);
    end
  end

  // Bytes handed to the core, zeros once the host fell behind on a write
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      pull_valid_ff <= 1'b0;
      pull_data_ff <= `FDCR_ZERO_BYTE;
    end
    else if (ce_in)
    begin
      pull_valid_ff <= core_pull_in && !dir_ff && (!empty || in_exec);
      if (core_pull_in && (empty || unr_ff))
      begin
        pull_data_ff <= `FDCR_ZERO_BYTE;
      end
      else if (core_pop)
      begin
        pull_data_ff <= fifo_mem[rd_ptr_ff];
      end
    end
  end

  // ========================================================================
  // Host request and direction flags
  assign thr_lvl = {1'b0, thr_ff} + 5'h01;
  assign free_cnt = cap - count_ff;
  always_comb
  begin
    nxt_rqm = 1'b0;
    if (phase_ff != fdcr_pkg::FDCR_PH_IDLE || !core_dir_read_in)
    begin
      if (core_dir_read_in)
      begin
        // Drained bytes stay readable after an overrun
        nxt_rqm = (fifo_en_ff && in_exec && !ovr_ff) ?
                  (count_ff >= thr_lvl) : !empty;
      end
      else
      begin
        nxt_rqm = (fifo_en_ff && in_exec) ? (free_cnt >= thr_lvl) :
                  empty;
        if (ovr_ff || unr_ff)
        begin
          nxt_rqm = 1'b0;
        end
      end
    end
  end

  // Registered flags toward host and core
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      rqm_ff <= 1'b0;
      dir_ff <= 1'b0;
      drain_ff <= 1'b1;
    end
    else if (ce_in)
    begin
      rqm_ff <= nxt_rqm;
      dir_ff <= core_dir_read_in;
      drain_ff <= empty;
    end
  end

  // ========================================================================
  // Software writable state
  // FIFO enable, threshold and forced change bits
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      fifo_en_ff <= 1'b0;
      thr_ff <= 4'h0;
      force_ff <= 2'h0;
    end
    else if (ce_in)
    begin
      if (soft_reset_in)
      begin
        fifo_en_ff <= 1'b0;
      end
      else if (wr_done && (idx == `FDCR_IDX_CTRL))
      begin
        fifo_en_ff <= pwdata_in[`FDCR_CTRL_FIFO_EN];
        thr_ff <= pwdata_in[`FDCR_CTRL_THR_HI:`FDCR_CTRL_THR_LO];
        force_ff <= pwdata_in[`FDCR_CTRL_FORCE_HI:`FDCR_CTRL_FORCE_LO];
      end
    end
  end

  // Data rate and no-precompensation, untouched by soft reset
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      rate_ff <= `FDCR_RATE_RESET;
      noprec_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      if (wr_done && (idx == `FDCR_IDX_STAT))
      begin
        rate_ff <= pwdata_in[1:0];
        if (mode == fdcr_pkg::FDCR_MODE_EXT)
        begin
          noprec_ff <= pwdata_in[`FDCR_CFG_NOPREC];
        end
      end
      else if (dsr_rate_wr_in)
      begin
        rate_ff <= dsr_rate_in;
      end
    end
  end

  // ========================================================================
  // Read data
  // Input status layout per interface mode
  always_comb
  begin
    stat_byte = 8'h00;
    stat_byte[7] = !media_changed_n_in || (force_ff != 2'h0);
    unique case (mode)
      fdcr_pkg::FDCR_MODE_ENH:
      begin
        stat_byte[0] = !((rate_ff == `FDCR_RATE_500K) ||
                         (rate_ff == `FDCR_RATE_1M));
        stat_byte[2:1] = rate_ff;
        stat_byte[6:3] = 4'hF;
      end
      fdcr_pkg::FDCR_MODE_EXT:
      begin
        stat_byte[1:0] = rate_ff;
        stat_byte[2] = noprec_ff;
        stat_byte[3] = dor_dma_gate_in;
      end
      fdcr_pkg::FDCR_MODE_BASIC:
      begin
        stat_byte[6:0] = 7'h00;
      end
    endcase
  end

  // Read multiplexer
  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    unique case (idx)
      `FDCR_IDX_DATA: nxt_prdata[7:0] = empty ? 8'h00 :
                                        fifo_mem[rd_ptr_ff];
      `FDCR_IDX_STAT: nxt_prdata[7:0] = stat_byte;
      `FDCR_IDX_CTRL: nxt_prdata = {22'h00_0000, force_ff, thr_ff, 3'h0,
                                    fifo_en_ff};
      `FDCR_IDX_INFO: nxt_prdata = {21'h00_0000, phase_ff, unr_ff, ovr_ff,
                                    count_ff, dir_ff, rqm_ff};
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  // One wait state: data sampled on entry, transfer ends a cycle later
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      lane_oe_ff <= 8'h00;
      pop_armed_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      pready_ff <= access && !pready_ff;
      pslverr_ff <= access && !pready_ff && !addr_ok;
      if (access && !pready_ff)
      begin
        prdata_ff <= (addr_ok && !pwrite_in) ? nxt_prdata : 32'h0000_0000;
        pop_armed_ff <= !empty;
        lane_oe_ff <= (idx == `FDCR_IDX_STAT &&
                       mode == fdcr_pkg::FDCR_MODE_BASIC) ?
                      8'h80 : 8'hFF;
      end
    end
  end

  // ========================================================================
  // Outputs
  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign data_lane_oe_out = lane_oe_ff;
  assign core_pull_valid_out = pull_valid_ff;
  assign core_pull_data_out = pull_data_ff;
  assign request_for_master_out = rqm_ff;
  assign transfer_direction_out = dir_ff;
  assign core_abort_out = abort_ff;
  assign core_underrun_out = unr_ff;
  assign core_drain_done_out = drain_ff;
  assign rate_sel_out = rate_ff;
  assign noprec_out = noprec_ff;

endmodule

// ===== tb/fdcr_core_model.sv
// Behavioural model of the controller core behind the data port
`timescale 1ns/1ns

module fdcr_core_model
(
  // Clock
  input wire logic clk_in,
  // Phase events: bit 0 command, 1 execution, 2 result, 3 done
  output logic [3:0] ev_out,
  // Byte exchange
  output logic dir_out,
  output logic push_out,
  output logic [7:0] push_data_out,
  output logic pull_out,
  input wire logic pull_valid_in,
  input wire logic [7:0] pull_data_in
);
  // Idle levels from time zero
  initial
  begin
    ev_out = 4'h0;
    dir_out = 1'b0;
    push_out = 1'b0;
    push_data_out = 8'h00;
    pull_out = 1'b0;
  end

  // One-cycle phase event
  task automatic event_pulse(input int k);
    @(posedge clk_in);
    ev_out[k] <= 1'b1;
    @(posedge clk_in);
    ev_out <= 4'h0;
  endtask

  // Host direction level
  task automatic set_dir(input logic r);
    @(posedge clk_in);
    dir_out <= r;
  endtask

  // Offers a byte; the data lines are scrambled once it is gone
  task automatic push(input logic [7:0] d);
    @(posedge clk_in);
    push_out <= 1'b1;
    push_data_out <= d;
    @(posedge clk_in);
    push_out <= 1'b0;
    push_data_out <= ~d;
  endtask

  // Asks a byte; the answer stands one cycle after the request
  task automatic pull(output logic v, output logic [7:0] d);
    @(posedge clk_in);
    pull_out <= 1'b1;
    @(posedge clk_in);
    pull_out <= 1'b0;
    @(posedge clk_in);
    v = pull_valid_in;
    d = pull_data_in;
  endtask
endmodule

// ===== tb/fdcr_regs_props.sv
// Checker of rate register and input status behaviour at the block ports
`timescale 1ns/1ns

module fdcr_regs_props
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic [7:0] data_lane_oe_out,
  // Side inputs
  input wire logic [1:0] mode_sel_in,
  input wire logic soft_reset_in,
  input wire logic dor_dma_gate_in,
  input wire logic dsr_rate_wr_in,
  input wire logic [1:0] dsr_rate_in,
  input wire logic core_dir_read_in,
  // Outputs watched
  input wire logic core_pull_valid_out,
  input wire logic [7:0] core_pull_data_out,
  input wire logic core_underrun_out,
  input wire logic transfer_direction_out,
  input wire logic [1:0] rate_sel_out,
  input wire logic noprec_out
);
  // ====
  // Completed accesses to the status and rate configuration place
  wire acc = psel_in && penable_in && pready_out && ce_in;
  wire st_wr = acc && pwrite_in && paddr_in == 8'h1C;
  wire st_rd = acc && !pwrite_in && paddr_in == 8'h1C;
  wire basic = mode_sel_in[0] == mode_sel_in[1];

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  property p_rate_wr;
    st_wr |=> rate_sel_out == $past(pwdata_in[1:0]);
  endproperty
  a_rate_wr: assert property (p_rate_wr) else $error("rate write");
  property p_noprec;
    st_wr |=> noprec_out == ($past(mode_sel_in) == 2'h2 ?
      $past(pwdata_in[2]) : $past(noprec_out));
  endproperty
  a_noprec: assert property (p_noprec) else $error("noprec write");
  property p_hw_rst;
    $past(reset_in) |-> rate_sel_out == 2'h2 && !noprec_out;
  endproperty
  a_hw_rst: assert property (p_hw_rst) else $error("reset rate");
  property p_soft;
    soft_reset_in && !dsr_rate_wr_in && !st_wr |=>
      $stable(rate_sel_out) && $stable(noprec_out);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset rate");
  property p_dsr;
    ce_in && dsr_rate_wr_in && !st_wr |=> rate_sel_out == $past(dsr_rate_in);
  endproperty
  a_dsr: assert property (p_dsr) else $error("rate pulse");
  property p_basic;
    st_rd && basic |-> data_lane_oe_out == 8'h80 && prdata_out[6:0] == 7'h00;
  endproperty
  a_basic: assert property (p_basic) else $error("basic lanes");
  property p_enh;
    st_rd && mode_sel_in == 2'h1 |->
      prdata_out[6:0] == {4'hF, rate_sel_out, ^rate_sel_out};
  endproperty
  a_enh: assert property (p_enh) else $error("enhanced layout");
  property p_ext;
    st_rd && mode_sel_in == 2'h2 |-> prdata_out[6:0] ==
      {3'h0, dor_dma_gate_in, noprec_out, rate_sel_out};
  endproperty
  a_ext: assert property (p_ext) else $error("extended layout");
  property p_dir;
    $past(ce_in) && !$past(reset_in) |->
      transfer_direction_out == $past(core_dir_read_in);
  endproperty
  a_dir: assert property (p_dir) else $error("direction flag");
  property p_under;
    core_underrun_out && core_pull_valid_out |-> core_pull_data_out == 8'h00;
  endproperty
  a_under: assert property (p_under) else $error("underrun byte");

  // Main scenarios reached
  c_wr: cover property (st_wr && mode_sel_in == 2'h2);
  c_rd: cover property (st_rd && basic);
  c_un: cover property (core_underrun_out && core_pull_valid_out);
endmodule

// ===== tb/tb.sv
// Testbench for the data port, input status and rate configuration block
`timescale 1ns/1ns
`include "fdcr_defines.svh"

module tb;
  // ====
  // Register byte addresses
  localparam logic [7:0] a_dat = {2'h0, `FDCR_IDX_DATA, 2'h0};
  localparam logic [7:0] a_st = {2'h0, `FDCR_IDX_STAT, 2'h0};
  localparam logic [7:0] a_ctl = {2'h0, `FDCR_IDX_CTRL, 2'h0};
  localparam logic [7:0] a_inf = {2'h0, `FDCR_IDX_INFO, 2'h0};
  // ====
  // Design signals
  logic clk_sys_in, reset_in, ce_in, psel_in, penable_in, pwrite_in;
  logic [7:0] paddr_in, data_lane_oe_out, core_push_data_in, d;
  logic [31:0] pwdata_in, prdata_out, rdat;
  logic pready_out, pslverr_out, soft_reset_in, media_changed_n_in, rerr, v;
  logic [1:0] mode_sel_in, dsr_rate_in, rate_sel_out;
  logic dor_dma_gate_in, dsr_rate_wr_in, core_cmd_start_in;
  logic core_exec_start_in, core_result_start_in, core_cmd_done_in;
  logic core_dir_read_in, core_push_in, core_pull_in, core_pull_valid_out;
  logic [7:0] core_pull_data_out;
  logic request_for_master_out, transfer_direction_out, core_abort_out;
  logic core_underrun_out, core_drain_done_out, noprec_out;
  logic [31:0] rst_tab [4] = '{32'h00, 32'h7D, 32'h0A, 32'h00};
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  fdcr_regs DUT
  (
    .clk_sys_in, .reset_in, .ce_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .data_lane_oe_out, .mode_sel_in, .soft_reset_in, .media_changed_n_in,
    .dor_dma_gate_in, .dsr_rate_wr_in, .dsr_rate_in, .core_cmd_start_in,
    .core_exec_start_in, .core_result_start_in, .core_cmd_done_in,
    .core_dir_read_in, .core_push_in, .core_push_data_in, .core_pull_in,
    .core_pull_valid_out, .core_pull_data_out, .request_for_master_out,
    .transfer_direction_out, .core_abort_out, .core_underrun_out,
    .core_drain_done_out, .rate_sel_out, .noprec_out
  );

  fdcr_core_model core
  (
    .clk_in(clk_sys_in),
    .ev_out({core_cmd_done_in, core_result_start_in, core_exec_start_in,
      core_cmd_start_in}),
    .dir_out(core_dir_read_in), .push_out(core_push_in),
    .push_data_out(core_push_data_in), .pull_out(core_pull_in),
    .pull_valid_in(core_pull_valid_out), .pull_data_in(core_pull_data_out)
  );

  // Clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  // Hang guard
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      results();
    end
  end

  // ====
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do
    begin
      @(posedge clk_sys_in);
    end
    while (pready_out !== 1'b1);
    rdat = prdata_out;
    rerr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ====
  // Main sequence
  initial
  begin
    reset_in = 1'b1;
    ce_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0;
    mode_sel_in = 2'h0;
    soft_reset_in = 1'b0;
    media_changed_n_in = 1'b1;
    dor_dma_gate_in = 1'b1;
    dsr_rate_wr_in = 1'b0;
    dsr_rate_in = 2'h0;
    repeat (6) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    for (int m = 0; m < 4; m++)
    begin
      mode_sel_in <= m[1:0];
      rd(a_st, rst_tab[m]);
    end
    // Rate and no-precompensation writes, soft reset, rate pulse
    mode_sel_in <= 2'h1;
    wr(a_st, 32'hFF);
    rd(a_st, 32'h7E);
    mode_sel_in <= 2'h2;
    wr(a_st, 32'hFD);
    soft_reset_in <= 1'b1;
    @(posedge clk_sys_in);
    soft_reset_in <= 1'b0;
    rd(a_st, 32'h0D);
    dsr_rate_wr_in <= 1'b1;
    dsr_rate_in <= 2'h1;
    @(posedge clk_sys_in);
    dsr_rate_wr_in <= 1'b0;
    dor_dma_gate_in <= 1'b0;
    media_changed_n_in <= 1'b0;
    rd(a_st, 32'h85);
    // Clock enable low: a rate pulse is ignored
    ce_in <= 1'b0;
    dsr_rate_wr_in <= 1'b1;
    dsr_rate_in <= 2'h3;
    @(posedge clk_sys_in);
    ce_in <= 1'b1;
    dsr_rate_wr_in <= 1'b0;
    rd(a_st, 32'h85);
    mode_sel_in <= 2'h0;
    wr(a_st, 32'hFF);
    mode_sel_in <= 2'h2;
    media_changed_n_in <= 1'b1;
    wr(a_ctl, 32'h100);
    rd(a_st, 32'h87);
    wr(a_ctl, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd(a_st, 32'h02);
    // Byte-wide exchange with the FIFO disabled
    core.event_pulse(0);
    rd(a_inf, 32'h201);
    wr(a_dat, 32'hA5);
    rd(a_inf, 32'h204);
    chk({31'h0, request_for_master_out}, 32'h0);
    core.pull(v, d);
    chk({23'h0, v, d}, 32'h1A5);
    core.set_dir(1'b1);
    core.push(8'h3C);
    rd(a_inf, 32'h207);
    chk({31'h0, request_for_master_out}, 32'h1);
    rd(a_dat, 32'h3C);
    // Underrun during execution
    core.set_dir(1'b0);
    core.event_pulse(1);
    core.pull(v, d);
    chk({23'h0, v, d}, 32'h100);
    rd(a_inf, 32'h700);
    chk({31'h0, core_abort_out}, 32'h1);
    core.event_pulse(2);
    core.event_pulse(3);
    core.event_pulse(0);
    @(posedge clk_sys_in);
    chk({31'h0, core_abort_out}, 32'h0);
    // FIFO mode: stale byte flushed, host stalls into an overrun, then drains
    wr(a_ctl, 32'h1);
    core.set_dir(1'b1);
    core.push(8'hEE);
    core.event_pulse(1);
    for (int i = 0; i < 17; i++) core.push(i[7:0]);
    rd(a_inf, 32'h6C3);
    for (int i = 0; i < 16; i++) rd(a_dat, i);
    repeat (2) @(posedge clk_sys_in);
    chk({31'h0, core_drain_done_out}, 32'h1);
    results();
  end
endmodule

bind fdcr_regs fdcr_regs_props u_props
(
  .clk_sys_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .prdata_out, .pready_out, .data_lane_oe_out, .mode_sel_in,
  .soft_reset_in, .dor_dma_gate_in, .dsr_rate_wr_in, .dsr_rate_in,
  .core_dir_read_in, .core_pull_valid_out, .core_pull_data_out,
  .core_underrun_out, .transfer_direction_out, .rate_sel_out, .noprec_out,
  .ce_in
);
